/* File: rps_pkg.sv */
// constants and types for reset and panel supervision
//
// Contract
// R01: the selection takes only 0 to 3 and 14 to 17, and starts at 14.
// R02: with selection 1, 3, 15 or 17 a reset request is taken only while a trip is active.
// R03: with selection 0, 2, 14 or 16 a reset request is taken at any time.
// R04: a taken reset shuts the output stage off and clears thermal and brake duty sums.
// R05: the panel reset key works only while a trip is active, whatever the selection.
// R06: with detection on, a panel absent for more than 1 s raises the disconnect alarm.
// R07: with selection 0, 1, 14 or 15 a panel loss raises no alarm and running goes on.
// R08: a panel already absent before power-on is not judged an alarm.
// R09: after a disconnect alarm the operator reconnects the panel and then resets.
// R10: panel jog with detection off decelerates to a stop when the panel goes away.
// R11: with serial traffic on the panel connector disconnect detection is off.
// R12: with selection 0 to 3 the stop key stops the motor only in panel mode.
// R13: with selection 14 to 17 the stop key stops the motor in every mode.
// R14: the selection may be written at any time and a parameter clear leaves it alone.
// R15: a panel stop in external mode shows the stop indication but raises no alarm.
// R16: the absence timer restarts from zero when the panel returns before the limit.
package rps_pkg;
    localparam int unsigned rps_clk_hz = 100_000_000;
    localparam int unsigned rps_absent_ms = 1000;
    localparam int unsigned rps_absent_cycles = rps_clk_hz / 1000 * rps_absent_ms;
    localparam logic [4:0] rps_sel_reset = 5'h0e;

    // register map, byte addresses
    localparam logic [7:0] rps_addr_sel = 8'h00;
    localparam logic [7:0] rps_addr_ctrl = 8'h04;
    localparam logic [7:0] rps_addr_status = 8'h08;

    // control register bits
    localparam int rps_ctrl_sel_write = 0;
    localparam int rps_ctrl_param_clear = 1;

    // status register bits
    localparam int rps_st_trip = 0;
    localparam int rps_st_alarm = 1;
    localparam int rps_st_stop_ind = 2;
    localparam int rps_st_shutoff = 3;
    localparam int rps_st_decel = 4;
    localparam int rps_st_panel_seen = 5;
    localparam int rps_st_rej = 6;

    typedef enum logic [1:0] {
        rps_mode_panel = 2'b00,
        rps_mode_ext = 2'b01,
        rps_mode_comm = 2'b10
    } rps_mode_e;

    typedef enum logic [1:0] {
        rps_pst_idle = 2'b00,
        rps_pst_counting = 2'b01,
        rps_pst_alarm = 2'b10
    } rps_pst_e;
endpackage : rps_pkg

/* File: rps_absence_timer.sv */
// panel absence timer with restart on reconnect
module rps_absence_timer
    import rps_pkg::*;
#(
    parameter int unsigned limit_cycles = rps_absent_cycles
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    output logic expired
);
    logic [31:0] cnt_q;

    // R16 restart on reconnect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 32'h0;
        end else if (!run) begin
            cnt_q <= 32'h0;
        end else if (cnt_q <= limit_cycles) begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // R06 strictly more than the limit
    assign expired = run && (cnt_q > limit_cycles);
endmodule : rps_absence_timer

/* File: rps_top.sv */
// reset acceptance, panel loss supervision and stop key decode
module rps_top
    import rps_pkg::*;
#(
    parameter int unsigned absent_cycles = rps_absent_cycles
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic reset_request_input,
    input wire logic comm_reset_cmd,
    input wire logic panel_reset_key,
    input wire logic panel_stop_key,
    input wire logic panel_present,
    input wire logic panel_serial_active,
    input wire logic panel_jog,
    input wire logic running,
    input wire logic trip_active,
    input wire logic [1:0] op_mode,
    input wire logic panel_stop_release,
    output logic drive_reset,
    output logic output_shutoff,
    output logic clear_thermal,
    output logic clear_brake_duty,
    output logic panel_disconnect_alarm,
    output logic alarm_stop,
    output logic alarm_output,
    output logic decel_stop,
    output logic panel_stop_indication
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic sel_legal(input logic [31:0] v);
        return (v <= 32'h3) || ((v >= 32'he) && (v <= 32'h11));
    endfunction : sel_legal

    // trip-only reset acceptance: 1, 3, 15, 17
    function automatic logic sel_trip_only(input logic [4:0] s);
        return s[0];
    endfunction : sel_trip_only

    // disconnect detection: 2, 3, 16, 17
    function automatic logic sel_detect(input logic [4:0] s);
        return s[4] || (s[1] && !s[3]);
    endfunction : sel_detect

    // stop key in every mode: 14 to 17
    function automatic logic sel_stop_all(input logic [4:0] s);
        return s[4] || s[3];
    endfunction : sel_stop_all

    function automatic logic in_panel_mode(input logic [1:0] m);
        return m == rps_mode_panel;
    endfunction : in_panel_mode

    ////////////////////////////////////////////////////////////////////////////
    // bus address phase

    logic [4:0] sel_q;
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic rej_q;
    logic [31:0] rdata_q;
    logic bus_go;

    assign bus_go = hsel && hready && htrans[1];
    // zero wait states, always okay response
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // capture the address phase for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= bus_go && hwrite;
            if (bus_go) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selection setting

    logic sel_wr;
    logic ctrl_wr;
    logic [4:0] sel_d;

    assign sel_wr = wr_pend_q && (addr_q == rps_addr_sel);
    assign ctrl_wr = wr_pend_q && (addr_q == rps_addr_ctrl);

    // R01 legal values only
    always_comb begin
        sel_d = sel_q;
        if (sel_wr && sel_legal(hwdata)) begin
            sel_d = hwdata[4:0];
        end
    end

    // R14 writable always, survives clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= rps_sel_reset;
        end else begin
            sel_q <= sel_d;
        end
    end

    // rejected write flag, write 1 to ctrl bit0 clears, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rej_q <= 1'b0;
        end else if (sel_wr && !sel_legal(hwdata)) begin
            rej_q <= 1'b1;
        end else if (ctrl_wr && hwdata[rps_ctrl_sel_write]) begin
            rej_q <= 1'b0;
        end
    end

    // decoded selection fields
    logic trip_only;
    logic detect_en;
    logic stop_all_modes;

    assign trip_only = sel_trip_only(sel_q);
    assign detect_en = sel_detect(sel_q) && !panel_serial_active;
    assign stop_all_modes = sel_stop_all(sel_q);

    ////////////////////////////////////////////////////////////////////////////
    // reset acceptance

    logic ext_req;
    logic accept;

    assign ext_req = reset_request_input || comm_reset_cmd;

    always_comb begin
        accept = 1'b0;
        // R02 trip only
        if (ext_req && trip_only && trip_active) begin
            accept = 1'b1;
        end
        // R03 always accepted
        if (ext_req && !trip_only) begin
            accept = 1'b1;
        end
        // R05 panel key needs trip
        if (panel_reset_key && trip_active) begin
            accept = 1'b1;
        end
    end

    // R04 shutoff and clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_reset <= 1'b0;
            output_shutoff <= 1'b0;
            clear_thermal <= 1'b0;
            clear_brake_duty <= 1'b0;
        end else begin
            drive_reset <= accept;
            output_shutoff <= accept || (pst_q == rps_pst_alarm);
            clear_thermal <= accept;
            clear_brake_duty <= accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // panel supervision

    rps_pst_e pst_q;
    logic seen_q;
    logic expired;
    logic absent_run;

    // R08 only after panel once seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 1'b0;
        end else if (panel_present) begin
            seen_q <= 1'b1;
        end
    end

    // R11 serial traffic disables detection
    assign absent_run = detect_en && seen_q && !panel_present && (pst_q != rps_pst_alarm);

    // absence timer, restarted on reconnect
    rps_absence_timer #(
        .limit_cycles(absent_cycles)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(absent_run),
        .expired(expired)
    );

    // R09 alarm held until accepted reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pst_q <= rps_pst_idle;
        end else begin
            case (pst_q)
                rps_pst_idle: begin
                    if (absent_run) begin
                        pst_q <= rps_pst_counting;
                    end
                end
                rps_pst_counting: begin
                    // R06 alarm after limit
                    if (expired) begin
                        pst_q <= rps_pst_alarm;
                    // R16 back to idle on return
                    end else if (!absent_run) begin
                        pst_q <= rps_pst_idle;
                    end
                end
                rps_pst_alarm: begin
                    if (accept) begin
                        pst_q <= rps_pst_idle;
                    end
                end
                default: begin
                    pst_q <= rps_pst_idle;
                end
            endcase
        end
    end

    logic alarm_now;

    // alarm level, dropped by an accepted reset
    assign alarm_now = (pst_q == rps_pst_alarm) && !accept;

    // R07 no alarm when detection off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            panel_disconnect_alarm <= 1'b0;
            alarm_stop <= 1'b0;
            alarm_output <= 1'b0;
        end else begin
            panel_disconnect_alarm <= alarm_now;
            alarm_stop <= alarm_now;
            // R15 panel stop gives no alarm
            alarm_output <= alarm_now || (trip_active && !accept);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stop key and jog

    logic key_stop;
    logic jog_loss;
    logic ind_q;

    always_comb begin
        key_stop = 1'b0;
        // R12 panel mode only
        if (panel_stop_key && !stop_all_modes && in_panel_mode(op_mode)) begin
            key_stop = 1'b1;
        end
        // R13 every mode
        if (panel_stop_key && stop_all_modes) begin
            key_stop = 1'b1;
        end
    end

    // R10 jog stops on panel loss
    assign jog_loss = panel_jog && running && !panel_present && !detect_en;

    // stop held while the indication stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decel_stop <= 1'b0;
        end else begin
            decel_stop <= key_stop || jog_loss || (ind_q && !panel_stop_release && !accept);
        end
    end

    // R15 stop indication, held until released or reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ind_q <= 1'b0;
        end else if (key_stop && stop_all_modes && !in_panel_mode(op_mode)) begin
            ind_q <= 1'b1;
        end else if (panel_stop_release || accept) begin
            ind_q <= 1'b0;
        end
    end

    assign panel_stop_indication = ind_q;

    ////////////////////////////////////////////////////////////////////////////
    // read data

    // status word, live levels and flags
    logic [31:0] status_w;

    always_comb begin
        status_w = 32'h0;
        status_w[rps_st_trip] = trip_active;
        status_w[rps_st_alarm] = panel_disconnect_alarm;
        status_w[rps_st_stop_ind] = ind_q;
        status_w[rps_st_shutoff] = output_shutoff;
        status_w[rps_st_decel] = decel_stop;
        status_w[rps_st_panel_seen] = seen_q;
        status_w[rps_st_rej] = rej_q;
    end

    // read data launched in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else if (bus_go && !hwrite) begin
            case (haddr[7:0])
                rps_addr_sel: begin
                    rdata_q <= {27'h0, sel_d};
                end
                rps_addr_status: begin
                    rdata_q <= status_w;
                end
                default: begin
                    rdata_q <= 32'h0;
                end
            endcase
        end
    end
endmodule : rps_top

/* File: rps_assertions.sv */
// checker for reset acceptance, panel loss and stop key decode
module rps_checker
    import rps_pkg::*;
#(
    parameter int unsigned absent_cycles = rps_absent_cycles
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reset_request_input,
    input wire logic comm_reset_cmd,
    input wire logic panel_reset_key,
    input wire logic panel_stop_key,
    input wire logic panel_present,
    input wire logic trip_active,
    input wire logic [1:0] op_mode,
    input wire logic drive_reset,
    input wire logic clear_thermal,
    input wire logic clear_brake_duty,
    input wire logic output_shutoff,
    input wire logic panel_disconnect_alarm,
    input wire logic alarm_stop,
    input wire logic alarm_output,
    input wire logic decel_stop
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] gone_q;
    logic seen_q;
    // consecutive absent samples, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gone_q <= 8'h00;
            seen_q <= 1'b0;
        end else begin
            gone_q <= panel_present ? 8'h00 : gone_q + {7'h00, gone_q != 8'hff};
            seen_q <= seen_q | panel_present;
        end
    end
    a_key_no_trip: assert property (
        panel_reset_key && !trip_active && !reset_request_input && !comm_reset_cmd
        |=> !drive_reset) else $error("panel key reset without trip");
    a_key_with_trip: assert property (
        panel_reset_key && trip_active |=> drive_reset) else $error("panel key ignored");
    a_reset_clears: assert property (
        drive_reset |-> clear_thermal && clear_brake_duty && output_shutoff)
        else $error("reset without clears");
    a_alarm_stops: assert property (
        panel_disconnect_alarm |-> alarm_stop && output_shutoff) else $error("alarm no stop");
    a_absent_long: assert property (
        $rose(panel_disconnect_alarm) |-> gone_q > absent_cycles) else $error("alarm early");
    a_never_seen: assert property (
        !seen_q |-> !panel_disconnect_alarm) else $error("alarm without panel");
    a_alarm_held: assert property (
        $fell(panel_disconnect_alarm) |-> drive_reset || $past(drive_reset))
        else $error("alarm dropped");
    a_alarm_out_cause: assert property (
        $rose(alarm_output) |-> $past(trip_active) || panel_disconnect_alarm)
        else $error("alarm output cause");
    a_panel_mode_stop: assert property (
        panel_stop_key && op_mode == rps_mode_panel |=> decel_stop) else $error("no stop");
    c_alarm: cover property ($rose(panel_disconnect_alarm));
    c_trip_reset: cover property (drive_reset && trip_active);
    c_ext_stop: cover property (decel_stop && op_mode == rps_mode_ext);
endmodule : rps_checker
bind rps_top rps_checker #(.absent_cycles(absent_cycles)) i_rps_checker (.hclk, .hresetn,
    .reset_request_input, .comm_reset_cmd, .panel_reset_key, .panel_stop_key,
    .panel_present, .trip_active, .op_mode, .drive_reset, .clear_thermal,
    .clear_brake_duty, .output_shutoff, .panel_disconnect_alarm, .alarm_stop,
    .alarm_output, .decel_stop);

/* File: rps_panel_model.sv */
// operator panel model: attach, keys and serial link
module rps_panel_model (
    input wire logic hclk,
    input wire logic attach,
    input wire logic press_reset,
    input wire logic press_stop,
    input wire logic serial,
    output logic panel_present = 1'b0,
    output logic panel_reset_key = 1'b0,
    output logic panel_stop_key = 1'b0,
    output logic panel_serial_active = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(posedge hclk) begin
        panel_present <= attach;
        // keys only from an attached panel
        panel_reset_key <= attach & press_reset;
        panel_stop_key <= attach & press_stop;
        panel_serial_active <= serial;
    end
endmodule : rps_panel_model

/* File: tb.sv */
// testbench for reset and panel supervision
module tb
    import rps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned ac = 20;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0, op_mode = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v, rs = 32'h43;
    logic att = 1'b0, prs = 1'b0, pst = 1'b0, ser = 1'b0, hit, hc;
    logic reset_request_input = 1'b0, comm_reset_cmd = 1'b0, running = 1'b0;
    logic trip_active = 1'b0, panel_stop_release = 1'b0, panel_jog = 1'b0;
    logic panel_present, panel_reset_key, panel_stop_key, panel_serial_active;
    logic drive_reset, output_shutoff, clear_thermal, clear_brake_duty, alarm_stop;
    logic panel_disconnect_alarm, alarm_output, decel_stop, panel_stop_indication;
    int n_fail = 0, checked = 0, cyc = 0, sel_m = 14, k;
    int sl[8] = '{0, 1, 2, 3, 14, 15, 16, 17};
    always #5 hclk = ~hclk;
    rps_top #(.absent_cycles(ac)) i_rps_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .reset_request_input, .comm_reset_cmd, .panel_reset_key, .panel_stop_key,
        .panel_present, .panel_serial_active, .panel_jog, .running, .trip_active,
        .op_mode, .panel_stop_release, .drive_reset, .output_shutoff, .clear_thermal,
        .clear_brake_duty, .panel_disconnect_alarm, .alarm_stop, .alarm_output,
        .decel_stop, .panel_stop_indication);
    rps_panel_model i_rps_panel_model (.hclk, .attach(att), .press_reset(prs),
        .press_stop(pst), .serial(ser), .panel_present, .panel_reset_key,
        .panel_stop_key, .panel_serial_active);
    function logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task conclude();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask : bus
    task pulse(input int src, input logic e);
        hit = 1'b0;
        hc = 1'b1;
        reset_request_input <= (src == 0);
        comm_reset_cmd <= (src == 1);
        prs <= (src == 2);
        for (int n = 0; n < 7; n++) begin
            @(posedge hclk);
            hit = hit | drive_reset;
            hc = hc & (!drive_reset | (clear_thermal & clear_brake_duty & output_shutoff));
            if (n == 1) begin
                reset_request_input <= 1'b0;
                comm_reset_cmd <= 1'b0;
                prs <= 1'b0;
            end
        end
        chk("reset", hit, e);
        chk("clears", hc, 1'b1);
    endtask : pulse
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, rps_addr_sel, 32'h0);
        chk("sel_init", v, sel_m);
        bus(1'b1, rps_addr_sel, 32'h12);
        bus(1'b0, rps_addr_sel, 32'h0);
        chk("sel_bad", v, sel_m);
        bus(1'b0, rps_addr_status, 32'h0);
        chk("rejected", v[6], 1'b1);
        bus(1'b1, rps_addr_ctrl, 32'h1);
        bus(1'b0, rps_addr_status, 32'h0);
        chk("rej_clear", v[6], 1'b0);
        bus(1'b1, 8'h0c, 32'h5);
        bus(1'b0, 8'h0c, 32'h0);
        chk("unmapped", v, 32'h0);
        chk("resp", hresp, 1'b0);
        bus(1'b1, rps_addr_sel, 32'h2);
        repeat (ac + 10) @(posedge hclk);
        chk("never_seen", panel_disconnect_alarm, 1'b0);
        att <= 1'b1;
        running <= 1'b1;
        foreach (sl[i]) begin
            bus(1'b1, rps_addr_sel, sl[i]);
            sel_m = sl[i];
            bus(1'b1, rps_addr_ctrl, 32'h2);
            bus(1'b0, rps_addr_sel, 32'h0);
            chk("sel_rw", v, sel_m);
            for (int t = 0; t < 2; t++) begin
                trip_active <= t[0];
                k = xs() % 3;
                pulse(k, k == 2 ? t[0] : (sel_m % 2 == 0 || t == 1));
            end
        end
        trip_active <= 1'b0;
        bus(1'b1, rps_addr_sel, 32'h2);
        att <= 1'b0;
        repeat (ac - 2) @(posedge hclk);
        att <= 1'b1;
        repeat (3) @(posedge hclk);
        att <= 1'b0;
        repeat (ac - 2) @(posedge hclk);
        chk("restart", panel_disconnect_alarm, 1'b0);
        repeat (10) @(posedge hclk);
        chk("alarm", panel_disconnect_alarm & alarm_stop & output_shutoff, 1'b1);
        att <= 1'b1;
        pulse(0, 1'b1);
        chk("cleared", panel_disconnect_alarm, 1'b0);
        for (int c = 0; c < 3; c++) begin
            bus(1'b1, rps_addr_sel, c == 0 ? 32'he : {30'h0, c == 1, 1'b0});
            ser <= (c == 1);
            panel_jog <= (c == 2);
            att <= 1'b0;
            repeat (ac + 10) @(posedge hclk);
            chk("no_alarm", panel_disconnect_alarm, 1'b0);
            chk("jog_stop", decel_stop, c == 2);
            att <= 1'b1;
            ser <= 1'b0;
            panel_jog <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        for (int s = 0; s < 17; s += 16) begin
            bus(1'b1, rps_addr_sel, s);
            for (int m = 0; m < 3; m++) begin
                op_mode <= m[1:0];
                pst <= 1'b1;
                repeat (3) @(posedge hclk);
                chk("stop", decel_stop, s == 16 || m == 0);
                chk("stop_ind", panel_stop_indication, s == 16 && m != 0);
                chk("alarm_out", alarm_output, 1'b0);
                pst <= 1'b0;
                panel_stop_release <= 1'b1;
                repeat (2) @(posedge hclk);
                panel_stop_release <= 1'b0;
                @(posedge hclk);
            end
        end
        conclude();
    end
endmodule : tb
